// ### scc_clk_switch.sv
// Glitch-free system clock source switch
`timescale 1ns/1ps
`include "scc_defines.svh"
module scc_clk_switch (
  input wire logic clk,
  input wire logic arst_n,
  scc_sw_if.sw sw
);

  scc_pkg::scc_sw_state_t state_ff;
  scc_pkg::scc_src_t act_ff;
  scc_pkg::scc_src_t tgt_ff;
  logic [2:0] gate_ff;
  logic [3:0] cnt_ff;
  scc_pkg::scc_src_t req;

  assign req = scc_pkg::scc_code_to_src(sw.sel_code);

  // ============================================================
  // Break before make: old gate drops, quiet gap, new gate opens
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= scc_pkg::SCC_SW_RUN;
      act_ff <= scc_pkg::SCC_SRC_RC;
      tgt_ff <= scc_pkg::SCC_SRC_RC;
      gate_ff <= 3'h2;
      cnt_ff <= 4'h0;
    end else begin
      case (state_ff)
        scc_pkg::SCC_SW_RUN: begin
          if (req != act_ff) begin
            gate_ff <= 3'h0;
            tgt_ff <= req;
            cnt_ff <= `SCC_SW_GAP;
            state_ff <= scc_pkg::SCC_SW_GAP;
          end
        end
        scc_pkg::SCC_SW_GAP: begin
          if (cnt_ff == 4'h0) begin
            gate_ff <= tgt_ff;
            cnt_ff <= `SCC_SW_SETTLE;
            state_ff <= scc_pkg::SCC_SW_SETTLE;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        scc_pkg::SCC_SW_SETTLE: begin
          if (cnt_ff == 4'h0) begin
            // Indicators move only once the new source is live
            act_ff <= tgt_ff;
            state_ff <= scc_pkg::SCC_SW_RUN;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        default: begin
          state_ff <= scc_pkg::SCC_SW_RUN;
        end
      endcase
    end
  end

  assign sw.act = act_ff;
  assign sw.gate = gate_ff;
  assign sw.busy = (state_ff != scc_pkg::SCC_SW_RUN);

endmodule // scc_clk_switch

// ### scc_defines.svh
// Constants of the system clock and power control block
`ifndef SCC_DEFINES_SVH
`define SCC_DEFINES_SVH

// ============================================================
// Register offsets
`define SCC_CLK_CTRL_ADDR 32'h5000000A
`define SCC_PWR_CTRL_ADDR 32'h50000010

// ============================================================
// clock_source_control fields
`define SCC_CC_XTAL_RUN 7
`define SCC_CC_RC_RUN 6
`define SCC_CC_SLOW_RUN 5
`define SCC_CC_SLOW_HI 4
`define SCC_CC_SLOW_LO 3
`define SCC_CC_XOFF 2
`define SCC_CC_SYS_HI 1
`define SCC_CC_SYS_LO 0
`define SCC_CC_SYS_RST 2'h1
`define SCC_CC_SLOW_RST 2'h0
`define SCC_CC_XOFF_RST 1'h0

// ============================================================
// power_domain_control fields
`define SCC_PC_RSVD7 7
`define SCC_PC_MAP 6
`define SCC_PC_DIV_HI 5
`define SCC_PC_DIV_LO 4
`define SCC_PC_RSVD3 3
`define SCC_PC_RADIO 2
`define SCC_PC_TIM 1
`define SCC_PC_REBOOT 0
`define SCC_PC_MAP_RST 1'h0
`define SCC_PC_DIV_RST 2'h0
`define SCC_PC_RADIO_RST 1'h1
`define SCC_PC_TIM_RST 1'h1
`define SCC_PC_REBOOT_RST 1'h0
`define SCC_RSVD_RST 1'h0

// ============================================================
// Clock switch timing, in system clock cycles
`define SCC_SW_GAP 4'h4
`define SCC_SW_SETTLE 4'h4

`endif

// ### scc_pkg.sv
// Types and helpers of the system clock and power control block
package scc_pkg;

  // One-hot system clock source, also the mux gate pattern
  typedef enum logic [2:0] {
    SCC_SRC_XTAL = 3'h1,
    SCC_SRC_RC = 3'h2,
    SCC_SRC_SLOW = 3'h4
  } scc_src_t;

  typedef enum logic [2:0] {
    SCC_SW_RUN = 3'h1,
    SCC_SW_GAP = 3'h2,
    SCC_SW_SETTLE = 3'h4
  } scc_sw_state_t;

  function automatic scc_src_t scc_code_to_src(input logic [1:0] code);
    case (code)
      2'h0: scc_code_to_src = SCC_SRC_XTAL;
      2'h1: scc_code_to_src = SCC_SRC_RC;
      default: scc_code_to_src = SCC_SRC_SLOW;
    endcase
  endfunction

endpackage

// ### scc_sw_if.sv
// Link between the register logic and the clock switch
`timescale 1ns/1ps
interface scc_sw_if;
  logic [1:0] sel_code;
  scc_pkg::scc_src_t act;
  logic [2:0] gate;
  logic busy;
  modport ctl (output sel_code, input act, input gate, input busy);
  modport sw (input sel_code, output act, output gate, output busy);
endinterface

// ### scc_top.sv
// System clock and power control: registers, switch, divider, pins
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`include "scc_defines.svh"
module scc_top (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [31:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic [2:0] sys_clk_gate,
  output logic fast_crystal_en,
  output logic [1:0] slow_clock_source_sel,
  input wire logic otp_mirror_active,
  output logic ahb_clk_en,
  output logic radio_domain_off,
  output logic timer_domain_off,
  input wire logic reference_on_signal,
  input wire logic power_woke_signal,
  output logic hw_reset_req,
  input wire logic gpio_p0_1_o,
  input wire logic gpio_p0_1_oe,
  input wire logic gpio_p0_2_o,
  input wire logic gpio_p0_2_oe,
  output logic p0_1_o,
  output logic p0_1_oe,
  output logic p0_2_o,
  output logic p0_2_oe
);

  // ============================================================
  // Declarations
  logic sys_sel_hi_ff;
  logic sys_sel_lo_ff;
  logic [1:0] slow_sel_ff;
  logic xoff_ff;
  logic map_ff;
  logic [1:0] div_ff;
  logic radio_ff;
  logic tim_ff;
  logic reboot_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [2:0] div_cnt_ff;
  logic ahb_en_ff;
  logic ref_s1_ff;
  logic ref_s2_ff;
  logic woke_s1_ff;
  logic woke_s2_ff;
  logic woke_s3_ff;
  logic woke_rise;
  logic hw_reset_ff;
  logic p01_o_ff;
  logic p01_oe_ff;
  logic p02_o_ff;
  logic p02_oe_ff;
  logic wr_cc;
  logic wr_pc;
  logic [7:0] cc_view;
  logic [7:0] pc_view;

  scc_sw_if sw_if ();

  // Mask of low counter bits that must be zero for an enable pulse
  function automatic logic [2:0] div_mask(input logic [1:0] code);
    case (code)
      2'h0: div_mask = 3'h0;
      2'h1: div_mask = 3'h1;
      2'h2: div_mask = 3'h3;
      default: div_mask = 3'h7;
    endcase
  endfunction

  // ============================================================
  // Address decode
  assign wr_cc = reg_wr && (reg_addr == `SCC_CLK_CTRL_ADDR);
  assign wr_pc = reg_wr && (reg_addr == `SCC_PWR_CTRL_ADDR);

  // ============================================================
  // clock_source_control writable fields
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sys_sel_hi_ff <= 1'(`SCC_CC_SYS_RST >> 1);
      sys_sel_lo_ff <= 1'(`SCC_CC_SYS_RST & 2'h1);
      slow_sel_ff <= `SCC_CC_SLOW_RST;
      xoff_ff <= `SCC_CC_XOFF_RST;
    end else if (wr_cc) begin
      // Indicator bits are read-only, writes to them are dropped
      sys_sel_hi_ff <= reg_wdata[`SCC_CC_SYS_HI];
      sys_sel_lo_ff <= reg_wdata[`SCC_CC_SYS_LO];
      // Not locked in hardware while in use; software must guard it
      slow_sel_ff <= reg_wdata[`SCC_CC_SLOW_HI:`SCC_CC_SLOW_LO];
      xoff_ff <= reg_wdata[`SCC_CC_XOFF];
    end
  end

  // ============================================================
  // power_domain_control writable fields
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      map_ff <= `SCC_PC_MAP_RST;
      div_ff <= `SCC_PC_DIV_RST;
      radio_ff <= `SCC_PC_RADIO_RST;
      tim_ff <= `SCC_PC_TIM_RST;
      reboot_ff <= `SCC_PC_REBOOT_RST;
    end else if (wr_pc) begin
      map_ff <= reg_wdata[`SCC_PC_MAP];
      div_ff <= reg_wdata[`SCC_PC_DIV_HI:`SCC_PC_DIV_LO];
      radio_ff <= reg_wdata[`SCC_PC_RADIO];
      tim_ff <= reg_wdata[`SCC_PC_TIM];
      reboot_ff <= reg_wdata[`SCC_PC_REBOOT];
    end
  end

  // ============================================================
  // Clock switch
  assign sw_if.sel_code = {sys_sel_hi_ff, sys_sel_lo_ff};

  scc_clk_switch u_switch (
    .clk(clk),
    .arst_n(arst_n),
    .sw(sw_if.sw)
  );

  assign sys_clk_gate = sw_if.gate;
  assign slow_clock_source_sel = slow_sel_ff;

  // Follows the register directly so the oscillator stops at once.
  // It stays low across sleep since only a register write or reset clears the bit.
  assign fast_crystal_en = ~xoff_ff;

  // ============================================================
  // Read views; reserved bits read their reset value
  always_comb begin
    cc_view = 8'h00;
    cc_view[`SCC_CC_XTAL_RUN] =
      (sw_if.act == scc_pkg::SCC_SRC_XTAL);
    cc_view[`SCC_CC_RC_RUN] = (sw_if.act == scc_pkg::SCC_SRC_RC);
    cc_view[`SCC_CC_SLOW_RUN] =
      (sw_if.act == scc_pkg::SCC_SRC_SLOW);
    cc_view[`SCC_CC_SLOW_HI:`SCC_CC_SLOW_LO] = slow_sel_ff;
    cc_view[`SCC_CC_XOFF] = xoff_ff;
    cc_view[`SCC_CC_SYS_HI] = sys_sel_hi_ff;
    cc_view[`SCC_CC_SYS_LO] = sys_sel_lo_ff;
  end

  always_comb begin
    pc_view = 8'h00;
    pc_view[`SCC_PC_RSVD7] = `SCC_RSVD_RST;
    pc_view[`SCC_PC_MAP] = map_ff;
    pc_view[`SCC_PC_DIV_HI:`SCC_PC_DIV_LO] = div_ff;
    pc_view[`SCC_PC_RSVD3] = `SCC_RSVD_RST;
    pc_view[`SCC_PC_RADIO] = radio_ff;
    pc_view[`SCC_PC_TIM] = tim_ff;
    pc_view[`SCC_PC_REBOOT] = reboot_ff;
  end

  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_rd) begin
      if (reg_addr == `SCC_CLK_CTRL_ADDR) begin
        nxt_rdata = cc_view;
      end else if (reg_addr == `SCC_PWR_CTRL_ADDR) begin
        nxt_rdata = pc_view;
      end else begin
        nxt_rdata = 8'h00;
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // ============================================================
  // AHB clock enable divider, active only during mirroring
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_ff <= 3'h0;
    end else begin
      div_cnt_ff <= div_cnt_ff + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ahb_en_ff <= 1'h1;
    end else begin
      ahb_en_ff <= ~otp_mirror_active ||
        ((div_cnt_ff & div_mask(div_ff)) == 3'h0);
    end
  end

  assign ahb_clk_en = ahb_en_ff;

  // ============================================================
  // Power domain requests
  assign radio_domain_off = radio_ff;
  assign timer_domain_off = tim_ff;

  // ============================================================
  // Synchronisers for the power controller signals
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_s1_ff <= 1'h0;
      ref_s2_ff <= 1'h0;
    end else begin
      ref_s1_ff <= reference_on_signal;
      ref_s2_ff <= ref_s1_ff;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      woke_s1_ff <= 1'h0;
      woke_s2_ff <= 1'h0;
      woke_s3_ff <= 1'h0;
    end else begin
      woke_s1_ff <= power_woke_signal;
      woke_s2_ff <= woke_s1_ff;
      woke_s3_ff <= woke_s2_ff;
    end
  end

  assign woke_rise = woke_s2_ff & ~woke_s3_ff;

  // ============================================================
  // Reboot on wake: one-cycle request to the reset controller
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hw_reset_ff <= 1'h0;
    end else begin
      hw_reset_ff <= woke_rise & reboot_ff;
    end
  end

  assign hw_reset_req = hw_reset_ff;

  // ============================================================
  // Diagnostic pin mapping overrides the GPIO drivers.
  // The reference pin doubles as debug clock, so a live debugger
  // is disturbed while mapping is on.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      p01_o_ff <= 1'h0;
      p01_oe_ff <= 1'h0;
      p02_o_ff <= 1'h0;
      p02_oe_ff <= 1'h0;
    end else if (map_ff) begin
      p02_o_ff <= ref_s2_ff;
      p02_oe_ff <= 1'h1;
      p01_o_ff <= woke_s2_ff;
      p01_oe_ff <= 1'h1;
    end else begin
      p02_o_ff <= gpio_p0_2_o;
      p02_oe_ff <= gpio_p0_2_oe;
      p01_o_ff <= gpio_p0_1_o;
      p01_oe_ff <= gpio_p0_1_oe;
    end
  end

  assign p0_1_o = p01_o_ff;
  assign p0_1_oe = p01_oe_ff;
  assign p0_2_o = p02_o_ff;
  assign p0_2_oe = p02_oe_ff;

endmodule // scc_top

// ### scc_top_sva.sv
// Port checker of the system clock and power control block
`timescale 1ns/1ps
`include "scc_defines.svh"
module scc_top_sva (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [31:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [2:0] sys_clk_gate,
  input wire logic fast_crystal_en,
  input wire logic [1:0] slow_clock_source_sel,
  input wire logic otp_mirror_active,
  input wire logic ahb_clk_en,
  input wire logic radio_domain_off,
  input wire logic timer_domain_off,
  input wire logic hw_reset_req
);
  logic wr_cc;
  logic wr_pc;
  assign wr_cc = reg_wr && reg_addr == `SCC_CLK_CTRL_ADDR;
  assign wr_pc = reg_wr && reg_addr == `SCC_PWR_CTRL_ADDR;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // ====
  // Clock switch: all gates shut for five cycles, then one source
  sequence s_gap_open;
    sys_clk_gate != 3'h0 ##1 sys_clk_gate == 3'h0;
  endsequence
  sequence s_gap_close;
    (sys_clk_gate == 3'h0) [*4] ##1 $onehot(sys_clk_gate);
  endsequence
  AST_SW_GAP: assert property (s_gap_open |=> s_gap_close)
    else $error("clock gap length wrong");
  AST_GATE_ONE: assert property ($onehot0(sys_clk_gate))
    else $error("two clock gates open");
  AST_IND_ONEHOT: assert property (reg_rd &&
    reg_addr == `SCC_CLK_CTRL_ADDR |=> $onehot(reg_rdata[7:5]))
    else $error("source indicators not one-hot");
  // ====
  // Control bits follow the write at the next edge; then bus clock enable and reset request checks
  AST_XTAL_OFF: assert property (wr_cc |=>
    fast_crystal_en == !$past(reg_wdata[2]))
    else $error("crystal enable wrong after write");
  AST_XTAL_HOLD: assert property (!wr_cc |=> $stable(fast_crystal_en))
    else $error("crystal enable moved without write");
  AST_SLOW_SEL: assert property (wr_cc |=>
    slow_clock_source_sel == $past(reg_wdata[4:3]))
    else $error("slow source select wrong");
  AST_RADIO: assert property (wr_pc |=>
    radio_domain_off == $past(reg_wdata[2]))
    else $error("radio domain control wrong");
  AST_TIMER: assert property (wr_pc |=>
    timer_domain_off == $past(reg_wdata[1]))
    else $error("timer domain control wrong");
  AST_AHB_FULL: assert property (!otp_mirror_active |=> ahb_clk_en)
    else $error("bus clock divided outside mirroring");
  AST_RESET_PULSE: assert property (hw_reset_req |=> !hw_reset_req)
    else $error("reset request longer than one cycle");
endmodule // scc_top_sva

bind scc_top scc_top_sva u_sva (.clk, .arst_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .sys_clk_gate, .fast_crystal_en,
  .slow_clock_source_sel, .otp_mirror_active, .ahb_clk_en,
  .radio_domain_off, .timer_domain_off, .hw_reset_req);

// ### scc_top_tb.sv
// Self-checking bench of the system clock and power control block
`timescale 1ns/1ps
`include "scc_defines.svh"
module scc_top_tb;
  logic clk, arst_n, wr, rd, mir, rf, wk, xen, ahb, rad, tim, rq;
  logic [31:0] adr;
  logic [7:0] wd, rdat;
  logic [2:0] gate;
  logic [1:0] ssel;
  logic [3:0] gp, pin;
  int n_mismatch, checks_done, cnt;
  localparam logic [31:0] CC = `SCC_CLK_CTRL_ADDR;
  localparam logic [31:0] PC = `SCC_PWR_CTRL_ADDR;
  scc_top dut (.clk(clk), .arst_n(arst_n), .reg_addr(adr),
    .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat),
    .sys_clk_gate(gate), .fast_crystal_en(xen),
    .slow_clock_source_sel(ssel), .otp_mirror_active(mir),
    .ahb_clk_en(ahb), .radio_domain_off(rad), .timer_domain_off(tim),
    .reference_on_signal(rf), .power_woke_signal(wk),
    .hw_reset_req(rq), .gpio_p0_1_o(gp[1]), .gpio_p0_1_oe(gp[0]),
    .gpio_p0_2_o(gp[3]), .gpio_p0_2_oe(gp[2]), .p0_1_o(pin[1]),
    .p0_1_oe(pin[0]), .p0_2_o(pin[3]), .p0_2_oe(pin[2]));
  // ====
  // Bus tasks and checks
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr_reg(input logic [31:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    adr <= a;
    wd <= v;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task rd_chk(input logic [31:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    adr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdat, e);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Counts high cycles of the reset request or of the bus clock enable
  task tally(input int n, input logic pick);
    cnt = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      cnt += pick ? rq : ahb;
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
  // ====
  // Main sequence
  initial begin
    arst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    adr = 32'h0;
    wd = 8'h00;
    mir = 1'b0;
    rf = 1'b0;
    wk = 1'b0;
    gp = 4'hA;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    cyc(1);
    chk({5'h0, gate}, 8'h02);
    chk({7'h0, xen}, 8'h01);
    chk({6'h0, rad, tim}, 8'h03);
    rd_chk(CC, 8'h41);
    rd_chk(PC, 8'h06);
    wr_reg(32'h5000000C, 8'hFF);
    rd_chk(32'h5000000C, 8'h00);
    wr_reg(CC, 8'hE1);
    rd_chk(CC, 8'h41);
    wr_reg(PC, 8'h8E);
    rd_chk(PC, 8'h06);
    // Slow source changes only while on the fast RC
    for (int k = 0; k < 4; k++) begin
      wr_reg(CC, 8'(k * 8 + 1));
      chk({6'h0, ssel}, 8'(k));
      rd_chk(CC, 8'(k * 8 + 8'h41));
      wr_reg(PC, 8'(k * 2));
      chk({6'h0, rad, tim}, 8'(k));
    end
    wr_reg(CC, 8'h05);
    chk({7'h0, xen}, 8'h00);
    wr_reg(CC, 8'h01);
    chk({7'h0, xen}, 8'h01);
    // Settle flags live outside; the crystal is taken as ready
    wr_reg(CC, 8'h00);
    cyc(1);
    chk({5'h0, gate}, 8'h00);
    cyc(5);
    chk({5'h0, gate}, 8'h01);
    cyc(4);
    rd_chk(CC, 8'h80);
    wr_reg(CC, 8'h02);
    cyc(12);
    rd_chk(CC, 8'h22);
    // Crystal off only once it no longer clocks the system
    wr_reg(CC, 8'h07);
    cyc(12);
    chk({5'h0, gate}, 8'h04);
    rd_chk(CC, 8'h27);
    wr_reg(PC, 8'h01);
    @(posedge clk);
    wk <= 1'b1;
    tally(8, 1'b1);
    chk(8'(cnt), 8'h01);
    chk({7'h0, xen}, 8'h00);
    @(posedge clk);
    wk <= 1'b0;
    wr_reg(PC, 8'h00);
    cyc(3);
    @(posedge clk);
    wk <= 1'b1;
    tally(8, 1'b1);
    chk(8'(cnt), 8'h00);
    wr_reg(CC, 8'h01);
    cyc(12);
    rd_chk(CC, 8'h41);
    // No debugger is attached, so the shared pin is free
    @(posedge clk);
    gp <= 4'h6;
    cyc(2);
    chk({4'h0, pin}, 8'h06);
    wr_reg(PC, 8'h40);
    cyc(3);
    chk({4'h0, pin}, 8'h07);
    @(posedge clk);
    rf <= 1'b1;
    wk <= 1'b0;
    cyc(4);
    chk({4'h0, pin}, 8'h0D);
    for (int d = 0; d < 4; d++) begin
      wr_reg(PC, 8'(d * 16 + 6));
      @(posedge clk);
      mir <= 1'b1;
      cyc(3);
      tally(64, 1'b0);
      chk(8'(cnt), 8'(64 >> d));
    end
    @(posedge clk);
    mir <= 1'b0;
    cyc(2);
    tally(16, 1'b0);
    chk(8'(cnt), 8'h10);
    conclude();
  end
endmodule // scc_top_tb
